// [rtl/tsq_timer.sv]
// timer channel: square wave, soft and hard strobe modes behind an ahb-lite slave
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
module tsq_timer #(
    parameter int CNT_W = tsq_pkg::TSQ_CNT_W
) (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    // ahb-lite slave
    input  wire tsq_pkg::tsq_ahb_req_s i_ahb,
    input  wire logic [31:0]          i_hwdata,
    output logic      [31:0]          o_hrdata,
    output logic                      o_hreadyout,
    output logic                      o_hresp,
    // timer pins
    input  wire logic                 i_count_clock_input,
    input  wire logic                 i_gate_trigger_input,
    output logic                      o_timer_output_pin
);
    import tsq_pkg::*;

    // whole state of the channel
    typedef struct packed {
        // bus data phase
        logic             wr_pend;
        logic [7:0]       wr_ofs;
        logic [31:0]      hrdata;
        // configuration
        tsq_mode_e        mode;
        logic             bcd;
        logic             two_byte;
        logic             lo_done;
        // counting
        logic [CNT_W-1:0] latch;
        logic [CNT_W-1:0] cnt;
        logic             pending;
        logic             loaded;
        logic             armed;
        logic             out;
    } tsq_state_s;

    tsq_state_s st_r;
    tsq_state_s st_nxt;

    logic [1:0]       rise;
    logic             tick;
    logic             trig;
    logic             addr_ok;
    logic [CNT_W-1:0] dec_one;
    logic [CNT_W-1:0] dec_two;
    logic [CNT_W-1:0] sq_load;
    logic [CNT_W-1:0] new_cnt;
    logic             count_wr_done;

    if (CNT_W != TSQ_CNT_W) begin : g_chk
        $error("tsq_timer serves a sixteen-bit count only");
    end

    // edges of the count clock and of the gate
    tsq_edge #(
        .W (2)
    ) u_edge (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_level ({i_gate_trigger_input, i_count_clock_input}),
        .o_rise  (rise)
    );

    assign tick = rise[0];
    assign trig = rise[1];

    // decrement by one for strobe modes
    tsq_dec #(
        .W (CNT_W)
    ) u_dec_one (
        .i_val   (st_r.cnt),
        .i_bcd   (st_r.bcd),
        .i_step2 (1'b0),
        .o_val   (dec_one)
    );

    // decrement by two for the square wave
    tsq_dec #(
        .W (CNT_W)
    ) u_dec_two (
        .i_val   (st_r.cnt),
        .i_bcd   (st_r.bcd),
        .i_step2 (1'b1),
        .o_val   (dec_two)
    );

    // odd counts start one lower so each half steps by two
    tsq_dec #(
        .W (CNT_W)
    ) u_dec_odd (
        .i_val   (st_r.latch),
        .i_bcd   (st_r.bcd),
        .i_step2 (1'b0),
        .o_val   (sq_load)
    );

    // a transfer is taken in the address phase only when the bus is ready
    assign addr_ok = i_ahb.hsel && i_ahb.hready
                     && (i_ahb.htrans == TSQ_HTRANS_NONSEQ || i_ahb.htrans == TSQ_HTRANS_SEQ);

    // assemble the count value being written in this data phase
    always_comb begin
        new_cnt       = st_r.latch;
        count_wr_done = 1'b0;
        if (st_r.wr_pend && st_r.wr_ofs == TSQ_OFS_COUNT) begin
            if (st_r.two_byte) begin
                // low byte first, the value counts only after the high byte
                if (st_r.lo_done) begin
                    new_cnt       = {i_hwdata[7:0], st_r.latch[7:0]};
                    count_wr_done = 1'b1;
                end else begin
                    new_cnt = {st_r.latch[CNT_W-1:8], i_hwdata[7:0]};
                end
            end else begin
                new_cnt       = i_hwdata[CNT_W-1:0];
                count_wr_done = 1'b1;
            end
        end
    end

    // next state: bus, then counting, then mode setup which overrides all but the count
    always_comb begin
        st_nxt = st_r;

        // address phase: latch writes, prepare read data now so reads are zero-wait
        st_nxt.wr_pend = addr_ok && i_ahb.hwrite;
        st_nxt.wr_ofs  = i_ahb.haddr[7:0];
        if (addr_ok && !i_ahb.hwrite) begin
            unique case (i_ahb.haddr[7:0])
                TSQ_OFS_CTRL: begin
                    st_nxt.hrdata = '0;
                    st_nxt.hrdata[TSQ_CTRL_MODE_LSB +: 2] = st_r.mode;
                    st_nxt.hrdata[TSQ_CTRL_BCD_BIT]       = st_r.bcd;
                    st_nxt.hrdata[TSQ_CTRL_TWO_BIT]       = st_r.two_byte;
                end
                TSQ_OFS_COUNT: begin
                    st_nxt.hrdata = 32'(st_r.latch);
                end
                TSQ_OFS_STATUS: begin
                    st_nxt.hrdata = 32'(st_r.cnt);
                    st_nxt.hrdata[TSQ_STAT_OUT_BIT]  = st_r.out;
                    st_nxt.hrdata[TSQ_STAT_RUN_BIT]  = st_r.loaded;
                    st_nxt.hrdata[TSQ_STAT_GATE_BIT] = i_gate_trigger_input;
                end
                // unmapped offsets read as zero with an okay answer
                default: begin
                    st_nxt.hrdata = '0;
                end
            endcase
        end

        // count write: square and soft strobe start on the first complete count written after setup
        if (st_r.wr_pend && st_r.wr_ofs == TSQ_OFS_COUNT) begin
            st_nxt.latch = new_cnt;
            if (st_r.two_byte) begin
                st_nxt.lo_done = !st_r.lo_done;
            end
            if (count_wr_done) begin
                unique case (st_r.mode)
                    TSQ_SQUARE: begin
                        // a running square wave picks the value up at its next half
                        if (!st_r.loaded) begin
                            st_nxt.pending = 1'b1;
                        end
                    end
                    TSQ_SOFT_STROBE: begin
                        st_nxt.pending = 1'b1;
                    end
                    TSQ_HARD_STROBE: begin
                        st_nxt.pending = st_r.pending;
                    end
                    default: begin
                        st_nxt.pending = 1'b0;
                    end
                endcase
            end
        end

        // counting per mode
        unique case (st_r.mode)
            TSQ_SQUARE: begin
                if (!i_gate_trigger_input) begin
                    // gate low halts the count and lifts a low output at once
                    st_nxt.out = 1'b1;
                end else if (tick && st_r.pending) begin
                    st_nxt.cnt     = st_r.latch[0] ? sq_load : st_r.latch;
                    st_nxt.pending = 1'b0;
                    st_nxt.loaded  = 1'b1;
                end else if (tick && st_r.loaded) begin
                    // odd counts end the high half at zero, the low half at two
                    if ((st_r.latch[0] && st_r.out && st_r.cnt == '0)
                        || ((!st_r.latch[0] || !st_r.out) && st_r.cnt == TSQ_SQ_TURN)) begin
                        st_nxt.cnt = st_r.latch[0] ? sq_load : st_r.latch;
                        st_nxt.out = !st_r.out;
                    end else begin
                        // even counts step from N to 2, never reaching zero
                        st_nxt.cnt = dec_two;
                    end
                end
                // set wins: a trigger on the loading tick is kept for the next one
                if (trig) begin
                    st_nxt.pending = 1'b1;
                end
            end
            TSQ_SOFT_STROBE, TSQ_HARD_STROBE: begin
                if (tick) begin
                    // a strobe lasts exactly one count clock
                    if (!st_r.out) begin
                        st_nxt.out = 1'b1;
                    end
                    if (st_r.pending) begin
                        // load on this tick, decrement from the next one
                        st_nxt.cnt     = st_r.latch;
                        st_nxt.pending = 1'b0;
                        st_nxt.loaded  = 1'b1;
                        st_nxt.armed   = 1'b1;
                    end else if (st_r.loaded
                                 && (i_gate_trigger_input || st_r.mode == TSQ_HARD_STROBE)) begin
                        // soft strobe holds while gate is low
                        st_nxt.cnt = dec_one;
                        if (st_r.armed && dec_one == '0) begin
                            st_nxt.out   = 1'b0;
                            st_nxt.armed = 1'b0;
                        end
                    end
                end
                // after the tick so a retrigger on a loading tick is not lost
                if (st_r.mode == TSQ_HARD_STROBE && trig) begin
                    st_nxt.pending = 1'b1;
                end
            end
            default: begin
                st_nxt.out = 1'b1;
            end
        endcase

        // mode setup restarts the channel with its output high
        if (st_r.wr_pend && st_r.wr_ofs == TSQ_OFS_CTRL
            && i_hwdata[TSQ_CTRL_MODE_LSB +: 2] != 2'h3) begin
            // switching into square mode needs a count clock since the old count
            st_nxt.mode     = tsq_mode_e'(i_hwdata[TSQ_CTRL_MODE_LSB +: 2]);
            st_nxt.bcd      = i_hwdata[TSQ_CTRL_BCD_BIT];
            st_nxt.two_byte = i_hwdata[TSQ_CTRL_TWO_BIT];
            st_nxt.lo_done  = 1'b0;
            st_nxt.pending  = 1'b0;
            st_nxt.loaded   = 1'b0;
            st_nxt.armed    = 1'b0;
            st_nxt.out      = 1'b1;
        end
    end

    // single register stage for the whole channel
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_r          <= '0;
            st_r.mode     <= TSQ_SQUARE;
            st_r.latch    <= TSQ_RST_COUNT;
            st_r.cnt      <= TSQ_RST_COUNT;
            st_r.out      <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // read data and pin straight from the state flops; ready tied high, response tied okay
    assign o_hrdata           = st_r.hrdata;
    assign o_hreadyout        = 1'b1;
    assign o_hresp            = 1'b0;
    assign o_timer_output_pin = st_r.out;
endmodule

// [rtl/tsq_pkg.sv]
// package of constants and types for the square-wave and strobe timer channel
// Behaviour
// - square wave loads first tick, reloads each half
// - even count steps two, reloads after two
// - odd count loads N-1, zero high, two low
// - odd count: high half one tick longer
// - square wave gate trigger reloads next tick
// - square wave count zero only when odd
// - soft strobe: output low one tick at zero
// - soft strobe fires once per count load
// - soft strobe with gate high counts next tick
// - soft strobe gate low holds the count
// - after strobe output high, count wraps on
// - hard strobe started and restarted by trigger
// - hard strobe loads next tick, counts after
// - hard strobe count write waits for trigger
// - square wave gate low stops, forces high
package tsq_pkg;

    // register byte offsets on the bus
    localparam logic [7:0]  TSQ_OFS_CTRL    = 8'h00;
    localparam logic [7:0]  TSQ_OFS_COUNT   = 8'h04;
    localparam logic [7:0]  TSQ_OFS_STATUS  = 8'h08;

    // control register fields
    localparam int          TSQ_CTRL_MODE_LSB = 0;
    localparam int          TSQ_CTRL_BCD_BIT  = 2;
    localparam int          TSQ_CTRL_TWO_BIT  = 3;

    // status register fields (count sits in the low bits)
    localparam int          TSQ_STAT_OUT_BIT  = 16;
    localparam int          TSQ_STAT_RUN_BIT  = 17;
    localparam int          TSQ_STAT_GATE_BIT = 18;

    // documented count width and the square-wave turn point
    localparam int          TSQ_CNT_W         = 16;
    localparam logic [15:0] TSQ_RST_COUNT     = 16'h0000;
    localparam logic [15:0] TSQ_SQ_TURN       = 16'h0002;

    // ahb transfer type encoding
    localparam logic [1:0]  TSQ_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  TSQ_HTRANS_SEQ    = 2'h3;

    // operating modes of the channel
    typedef enum logic [1:0] {
        TSQ_SQUARE,
        TSQ_SOFT_STROBE,
        TSQ_HARD_STROBE
    } tsq_mode_e;

    // address-phase signals of the bus master
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
    } tsq_ahb_req_s;

endpackage

// [rtl/tsq_edge.sv]
// rising-edge detector for a group of synchronous inputs
module tsq_edge #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    // levels and their rising edges
    input  wire logic [W-1:0] i_level,
    output logic      [W-1:0] o_rise
);
    import tsq_pkg::*;

    typedef struct packed {
        logic [W-1:0] prev;
    } tsq_edge_s;

    tsq_edge_s st_r;
    tsq_edge_s st_nxt;

    if (W < 1) begin : g_chk
        $error("tsq_edge needs at least one input");
    end

    // remember last level for every input
    always_comb begin
        st_nxt      = st_r;
        st_nxt.prev = i_level;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            // take the present levels so no false edge follows reset
            st_r.prev <= i_level;
        end else begin
            st_r <= st_nxt;
        end
    end

    // one edge term per input bit
    for (genvar b = 0; b < W; b++) begin : g_bit
        assign o_rise[b] = i_level[b] & ~st_r.prev[b];
    end
endmodule

// [rtl/tsq_dec.sv]
// decrement by one or two in binary or packed decimal, wrapping at zero
module tsq_dec #(
    parameter int W = 16
) (
    // value and controls
    input  wire logic [W-1:0] i_val,
    input  wire logic         i_bcd,
    input  wire logic         i_step2,
    // result
    output logic      [W-1:0] o_val
);
    import tsq_pkg::*;

    localparam int D = W / 4;

    logic [D:0]   borrow;
    logic [W-1:0] bcd_val;
    logic [W-1:0] bin_val;

    if (W < 4 || (W % 4) != 0) begin : g_chk
        $error("tsq_dec width must be a multiple of four");
    end

    // the step enters the lowest digit as its borrow
    assign borrow[0] = 1'b1;
    assign bin_val   = i_val - (i_step2 ? W'(2) : W'(1));

    // one subtractor per decimal digit, borrows ripple upward
    for (genvar d = 0; d < D; d++) begin : g_dig
        logic [4:0] sub;
        logic [4:0] dig;
        assign dig = {1'b0, i_val[4*d +: 4]};
        assign sub = (d == 0) ? (i_step2 ? 5'h02 : 5'h01) : {4'h0, borrow[d]};
        assign borrow[d+1] = dig < sub;
        assign bcd_val[4*d +: 4] = (dig < sub) ? 4'(dig + 5'h0a - sub) : 4'(dig - sub);
    end

    assign o_val = i_bcd ? bcd_val : bin_val;
endmodule

// [verification/tsq_far.sv]
// far-side model: the count clock that drives the timer channel
module tsq_far #(
    parameter int HALF = 8
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // count clock towards the channel
    output logic      o_count_clock
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] cnt_r;

    // free-running divider; ticks stay far apart so host writes fit between them
    always_ff @(posedge i_clk) begin
        if (!i_rstn || cnt_r == 8'(2 * HALF - 1)) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    // every period is a full rise then fall, so mode changes always see one pulse
    assign o_count_clock = (cnt_r >= 8'(HALF));
endmodule

// [verification/tsq_timer_chk.sv]
// port-level checks for the timer channel
module tsq_timer_chk #(
    parameter int CNT_W = tsq_pkg::TSQ_CNT_W
) (
    // clock, reset and bus
    input wire logic                  i_clk,
    input wire logic                  i_rstn,
    input wire tsq_pkg::tsq_ahb_req_s i_ahb,
    input wire logic [31:0]           i_hwdata,
    input wire logic [31:0]           o_hrdata,
    input wire logic                  o_hreadyout,
    input wire logic                  o_hresp,
    // timer pins
    input wire logic                  i_count_clock_input,
    input wire logic                  i_gate_trigger_input,
    input wire logic                  o_timer_output_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    import tsq_pkg::*;

    logic       cc_r, gt_r, gt_rr, wr_dp_r, o_r, tick_w, ctrl_w, strb_w, rd_w, to_w;
    logic [7:0] adr_r;
    logic [1:0] mode_r, lowt_r, nstb_r;

    assign to_w = o_timer_output_pin;
    assign rd_w = i_ahb.hsel & i_ahb.hready & i_ahb.htrans[1] & ~i_ahb.hwrite;
    // tick seen in the same cycle as the channel sees it, so its effect lands one edge later
    assign tick_w = i_count_clock_input & ~cc_r;
    // mode code 3 is dropped by the slave, so it must not count as a setup here either
    assign ctrl_w = wr_dp_r && adr_r == TSQ_OFS_CTRL && i_hwdata[1:0] != 2'h3;
    assign strb_w = mode_r != 2'h0;

    // shadow of pin history, mode, low-pulse ticks and strobes since the last start
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            {cc_r, gt_r, gt_rr, wr_dp_r, o_r} <= 5'h01;
            {adr_r, mode_r, lowt_r, nstb_r} <= 14'h0;
        end else begin
            {cc_r, gt_r, gt_rr, o_r} <= {i_count_clock_input, i_gate_trigger_input, gt_r, to_w};
            wr_dp_r <= i_ahb.hsel & i_ahb.hready & i_ahb.htrans[1] & i_ahb.hwrite;
            adr_r <= i_ahb.haddr[7:0];
            if (ctrl_w) begin
                mode_r <= i_hwdata[1:0];
            end
            lowt_r <= to_w ? 2'h0 : lowt_r + {1'b0, tick_w};
            if (ctrl_w || (wr_dp_r && adr_r == TSQ_OFS_COUNT) || (gt_r & ~gt_rr)) begin
                nstb_r <= 2'h0;
            end else if (o_r & ~to_w) begin
                nstb_r <= nstb_r + 2'h1;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    hready_one_a: assert property (o_hreadyout) else $error("wait state inserted");
    resp_okay_a: assert property (!o_hresp) else $error("error response seen");
    rdata_hold_a: assert property (!$past(rd_w) |-> $stable(o_hrdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd_w && i_ahb.haddr[7:0] > TSQ_OFS_STATUS
        |=> o_hrdata == 32'h0) else $error("unmapped read not zero");
    fall_by_tick_a: assert property ($fell(to_w) |-> $past(tick_w))
        else $error("output fell without a tick");
    rise_by_cause_a: assert property ($rose(to_w) |-> $past(tick_w) || $past(ctrl_w)
        || !$past(i_gate_trigger_input) || !$past(i_gate_trigger_input, 2))
        else $error("output rose without a cause");
    strobe_width_a: assert property (strb_w && !to_w |-> lowt_r == 2'h0)
        else $error("strobe longer than one tick");
    strobe_once_a: assert property (strb_w && $fell(to_w) |-> nstb_r == 2'h0)
        else $error("second strobe for one load");
    gate_force_a: assert property (mode_r == 2'h0 && !i_gate_trigger_input && !to_w
        |-> ##[1:2] to_w) else $error("gate low did not force output high");
    setup_high_a: assert property (ctrl_w |=> to_w) else $error("setup left output low");

    cover property (strb_w && $fell(to_w));
    cover property (mode_r == 2'h0 && $rose(to_w) && $past(tick_w));
    cover property (rd_w && i_ahb.haddr[7:0] > TSQ_OFS_STATUS);
endmodule

// [verification/tb_top.sv]
// self-checking bench for the square-wave and strobe timer channel
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tsq_pkg::*;

    logic         i_clk = 1'b0;
    logic         i_rstn = 1'b0;
    logic         hwrite = 1'b0;
    logic         gate = 1'b1;
    logic [1:0]   htrans = 2'h0;
    logic [31:0]  haddr = 32'h0;
    logic [31:0]  hwdata = 32'h0;
    logic [31:0]  hrdata;
    logic         hrdy, hresp, cc, timer_output_pin;
    tsq_ahb_req_s req;
    int           n_mismatch = 0;
    int           check_count = 0;
    int           cyc = 0;

    assign req = '{1'b1, haddr, htrans, hwrite, 3'h2, hrdy};

    always #2.5 i_clk = ~i_clk;

    tsq_far u_far (.i_clk(i_clk), .i_rstn(i_rstn), .o_count_clock(cc));
    tsq_timer u_dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_ahb(req), .i_hwdata(hwdata), .o_hrdata(hrdata),
        .o_hreadyout(hrdy), .o_hresp(hresp), .i_count_clock_input(cc),
        .i_gate_trigger_input(gate), .o_timer_output_pin(timer_output_pin)
    );

    task automatic end_of_test();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one single transfer; address phase held until hready, then the data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge i_clk);
        htrans <= TSQ_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge i_clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    // wait one tick, let it act, then compare the pin and the live count (-1 skips)
    task automatic tk(input int eo, input int ec);
        logic [31:0] q;
        @(posedge cc);
        repeat (3) @(posedge i_clk);
        #1;
        if (eo >= 0) check({31'h0, timer_output_pin}, eo);
        if (ec >= 0) begin
            bus(1'b0, TSQ_OFS_STATUS, 32'h0, q);
            check({16'h0, q[15:0]}, ec);
        end
    endtask

    task automatic gt(input logic v);
        @(posedge i_clk);
        gate <= v;
    endtask

    // cut a hang short
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // main sequence: reset, registers, then each mode in turn
    initial begin
        logic [31:0] q;
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        rdc(TSQ_OFS_CTRL, 32'h0);
        rdc(8'h0c, 32'h0);
        tk(1, -1);
        // soft strobe, count 2: one low tick, then wrap and no second strobe
        wr(TSQ_OFS_CTRL, 32'h1);
        wr(TSQ_OFS_COUNT, 32'h2);
        rdc(TSQ_OFS_CTRL, 32'h1);
        tk(1, 2);
        tk(1, 1);
        tk(0, 0);
        tk(1, 32'hffff);
        tk(1, 32'hfffe);
        // two-byte load, then gate low holds the count
        wr(TSQ_OFS_CTRL, 32'h9);
        wr(TSQ_OFS_COUNT, 32'h2);
        tk(1, -1);
        bus(1'b0, TSQ_OFS_STATUS, 32'h0, q);
        check({31'h0, q[TSQ_STAT_RUN_BIT]}, 32'h0);
        wr(TSQ_OFS_COUNT, 32'h0);
        tk(1, 2);
        gt(1'b0);
        tk(1, 2);
        tk(1, 2);
        gt(1'b1);
        tk(1, 1);
        tk(0, 0);
        tk(1, 32'hffff);
        // decimal wrap
        wr(TSQ_OFS_CTRL, 32'h5);
        wr(TSQ_OFS_COUNT, 32'h1);
        tk(1, 1);
        tk(0, 0);
        tk(1, 32'h9999);
        tk(1, 32'h9998);
        tk(1, -1);
        // square wave, even count 4: two ticks per half, never zero
        wr(TSQ_OFS_CTRL, 32'h0);
        wr(TSQ_OFS_COUNT, 32'h4);
        tk(1, 4);
        tk(1, 2);
        tk(0, 4);
        tk(0, 2);
        tk(1, 4);
        // odd count 5: loads 4, high half three ticks, low half two
        wr(TSQ_OFS_CTRL, 32'h0);
        wr(TSQ_OFS_COUNT, 32'h5);
        tk(1, 4);
        tk(1, 2);
        tk(1, 0);
        tk(0, 4);
        tk(0, 2);
        tk(1, 4);
        tk(1, 2);
        tk(1, 0);
        tk(0, 4);
        // gate low in the low half forces high and freezes; a trigger reloads
        gt(1'b0);
        repeat (3) @(posedge i_clk);
        #1;
        check({31'h0, timer_output_pin}, 32'h1);
        tk(1, 4);
        gt(1'b1);
        tk(-1, 4);
        // hard strobe: count write alone starts nothing, trigger starts and restarts
        wr(TSQ_OFS_CTRL, 32'h2);
        wr(TSQ_OFS_COUNT, 32'h2);
        gt(1'b0);
        tk(1, -1);
        gt(1'b1);
        tk(1, 2);
        tk(1, 1);
        tk(0, 0);
        tk(1, 32'hffff);
        wr(TSQ_OFS_COUNT, 32'h3);
        gt(1'b0);
        tk(1, 32'hfffe);
        gt(1'b1);
        tk(1, 3);
        tk(1, 2);
        tk(1, 1);
        tk(0, 0);
        tk(1, 32'hffff);
        // stored count, pin, run and gate flags, then an illegal mode code is ignored
        rdc(TSQ_OFS_COUNT, 32'h3);
        bus(1'b0, TSQ_OFS_STATUS, 32'h0, q);
        check({29'h0, q[TSQ_STAT_GATE_BIT:TSQ_STAT_OUT_BIT]}, 32'h7);
        wr(TSQ_OFS_CTRL, 32'h7);
        rdc(TSQ_OFS_CTRL, 32'h2);
        end_of_test();
    end
endmodule

bind tsq_timer tsq_timer_chk #(.CNT_W(CNT_W)) u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ahb(i_ahb), .i_hwdata(i_hwdata),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_count_clock_input(i_count_clock_input), .i_gate_trigger_input(i_gate_trigger_input),
    .o_timer_output_pin(o_timer_output_pin)
);
